// ### hdl/dadg_pkg.sv
// Constants and types shared by the dual data address generator
package dadg_pkg;

	localparam int PTR_W    = 16;
	localparam int PAGE_W   = 8;
	localparam int ADDR_W   = 24;
	localparam int IMM_W    = 8;
	localparam int NUM_PTR  = 4;
	localparam int IDX_W    = 2;
	localparam int NUM_UNIT = 2;
	localparam int NUM_BANK = 2;

	// Unit 0 drives the data memory side, unit 1 the program memory side
	localparam int UNIT_DM = 0;
	localparam int UNIT_PM = 1;

	localparam logic [PTR_W-1:0]  PTR_RST  = 16'h0000;
	localparam logic [PAGE_W-1:0] PAGE_RST = 8'h00;

	typedef enum logic [2:0] {
		MODE_POST_REG,
		MODE_PRE_REG,
		MODE_PRE_KEEP_REG,
		MODE_POST_IMM,
		MODE_PRE_IMM
	} acc_mode_t;

	typedef enum logic [2:0] {
		WR_PTR,
		WR_MOD,
		WR_LEN,
		WR_BASE,
		WR_PAGE
	} wr_kind_t;

endpackage : dadg_pkg

// ### hdl/data_address_unit.sv
// Pointer modify and modulo wrap arithmetic for one address generator
`timescale 1ns/1ps
`default_nettype none

module data_address_unit
	import dadg_pkg::*;
#(
	parameter int W = PTR_W
) (
	// Selected register values
	input  wire logic [W-1:0] ptr_i,
	input  wire logic [W-1:0] mod_i,
	input  wire logic [W-1:0] len_i,
	input  wire logic [W-1:0] base_i,
	// Modify before forming the address
	input  wire logic         pre_i,
	// Results
	output logic      [W-1:0] addr_o,
	output logic      [W-1:0] ptr_nxt_o
);

	logic        [W-1:0] idx;
	logic signed [W+1:0] idx_x;
	logic signed [W+1:0] mod_x;
	logic signed [W+1:0] len_x;
	logic signed [W+1:0] sum_x;
	logic signed [W+1:0] wrap_x;
	logic                circ;
	logic                under;
	logic                over;
	logic        [W-1:0] lin;

	// Work relative to base so that wrap never depends on the page
	assign idx    = ptr_i - base_i;
	assign idx_x  = $signed({2'b00, idx});
	assign mod_x  = $signed({{2{mod_i[W-1]}}, mod_i});
	assign len_x  = $signed({2'b00, len_i});
	assign sum_x  = idx_x + mod_x;
	assign circ   = |len_i;
	assign under  = sum_x[W+1];
	assign over   = !under && (sum_x >= len_x);
	// Single correction only: a step larger than the length is not folded
	assign wrap_x = under ? sum_x + len_x : (over ? sum_x - len_x : sum_x);
	assign lin    = ptr_i + mod_i;
	// Pointer is 16 bits, so any wrap stays inside the current page
	assign ptr_nxt_o = circ ? base_i + wrap_x[W-1:0] : lin;
	assign addr_o    = pre_i ? ptr_nxt_o : ptr_i;

endmodule : data_address_unit

`default_nettype wire

// ### hdl/dual_data_address_generator.sv
// Two data address generators with banked pointer registers and one unbanked page register per generator
`timescale 1ns/1ps
`default_nettype none

module dual_data_address_generator
	import dadg_pkg::*;
#(
	parameter int PW = PTR_W,
	parameter int GW = PAGE_W,
	parameter int IW = IMM_W
) (
	// Clock, reset, enable
	input  wire logic          mclk_i,
	input  wire logic          resetn_i,
	input  wire logic          ce_i,
	// Register write port from decode
	input  wire logic          wr_en_i,
	input  wire logic          wr_unit_i,
	input  wire wr_kind_t      wr_kind_i,
	input  wire logic [IDX_W-1:0] wr_idx_i,
	input  wire logic [PW-1:0] wr_data_i,
	// Register set select
	input  wire logic          bank_sel_i,
	output logic               bank_o,
	// Data memory side request
	input  wire logic          dm_en_i,
	input  wire acc_mode_t     dm_mode_i,
	input  wire logic [IDX_W-1:0] dm_pidx_i,
	input  wire logic [IDX_W-1:0] dm_midx_i,
	input  wire logic [IW-1:0] dm_imm_i,
	// Program memory side request
	input  wire logic          pm_en_i,
	input  wire acc_mode_t     pm_mode_i,
	input  wire logic [IDX_W-1:0] pm_pidx_i,
	input  wire logic [IDX_W-1:0] pm_midx_i,
	input  wire logic [IW-1:0] pm_imm_i,
	// Address outputs
	output logic [GW+PW-1:0]   dm_addr_o,
	output logic               dm_vld_o,
	output logic [GW+PW-1:0]   pm_addr_o,
	output logic               pm_vld_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Register storage

	logic [PW-1:0] ptr_r  [NUM_UNIT][NUM_BANK][NUM_PTR];
	logic [PW-1:0] mod_r  [NUM_UNIT][NUM_BANK][NUM_PTR];
	logic [PW-1:0] len_r  [NUM_UNIT][NUM_BANK][NUM_PTR];
	logic [PW-1:0] base_r [NUM_UNIT][NUM_BANK][NUM_PTR];
	logic [GW-1:0] page_r [NUM_UNIT];
	logic          bank_r;
	logic [GW+PW-1:0] addr_r [NUM_UNIT];
	logic [NUM_UNIT-1:0] vld_r;

	////////////////////////////////////////////////////////////////////////////////
	// Request decode per generator

	logic             acc_en  [NUM_UNIT];
	acc_mode_t        acc_mode[NUM_UNIT];
	logic [IDX_W-1:0] acc_pidx[NUM_UNIT];
	logic [IDX_W-1:0] acc_midx[NUM_UNIT];
	logic [IW-1:0]    acc_imm [NUM_UNIT];
	logic [PW-1:0]    sel_ptr [NUM_UNIT];
	logic [PW-1:0]    sel_mod [NUM_UNIT];
	logic [PW-1:0]    sel_len [NUM_UNIT];
	logic [PW-1:0]    sel_base[NUM_UNIT];
	logic [PW-1:0]    step    [NUM_UNIT];
	logic             use_imm [NUM_UNIT];
	logic             is_pre  [NUM_UNIT];
	logic             do_upd  [NUM_UNIT];
	logic [PW-1:0]    calc_adr[NUM_UNIT];
	logic [PW-1:0]    calc_nxt[NUM_UNIT];

	assign acc_en[UNIT_DM]   = dm_en_i;
	assign acc_mode[UNIT_DM] = dm_mode_i;
	assign acc_pidx[UNIT_DM] = dm_pidx_i;
	assign acc_midx[UNIT_DM] = dm_midx_i;
	assign acc_imm[UNIT_DM]  = dm_imm_i;
	assign acc_en[UNIT_PM]   = pm_en_i;
	assign acc_mode[UNIT_PM] = pm_mode_i;
	assign acc_pidx[UNIT_PM] = pm_pidx_i;
	assign acc_midx[UNIT_PM] = pm_midx_i;
	assign acc_imm[UNIT_PM]  = pm_imm_i;

	for (genvar u = 0; u < NUM_UNIT; u++) begin : g_unit
		assign sel_ptr[u]  = ptr_r[u][bank_r][acc_pidx[u]];
		assign sel_mod[u]  = mod_r[u][bank_r][acc_midx[u]];
		assign sel_len[u]  = len_r[u][bank_r][acc_pidx[u]];
		assign sel_base[u] = base_r[u][bank_r][acc_pidx[u]];
		assign use_imm[u]  = (acc_mode[u] == MODE_POST_IMM) || (acc_mode[u] == MODE_PRE_IMM);
		assign is_pre[u]   = (acc_mode[u] == MODE_PRE_REG) || (acc_mode[u] == MODE_PRE_KEEP_REG)
			|| (acc_mode[u] == MODE_PRE_IMM);
		// Immediate offset is sign extended two's complement
		assign step[u]     = use_imm[u] ? {{(PW-IW){acc_imm[u][IW-1]}}, acc_imm[u]}
			: sel_mod[u];
		assign do_upd[u]   = acc_en[u] && (acc_mode[u] != MODE_PRE_KEEP_REG);

		data_address_unit #(
			.W         (PW)
		) u_calc (
			.ptr_i     (sel_ptr[u]),
			.mod_i     (step[u]),
			.len_i     (sel_len[u]),
			.base_i    (sel_base[u]),
			.pre_i     (is_pre[u]),
			.addr_o    (calc_adr[u]),
			.ptr_nxt_o (calc_nxt[u])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// State update

	// A decode write to the same pointer in the same cycle beats the update
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bank_r <= 1'b0;
			vld_r  <= '0;
			for (int u = 0; u < NUM_UNIT; u++) begin
				page_r[u] <= PAGE_RST;
				addr_r[u] <= '0;
				for (int b = 0; b < NUM_BANK; b++) begin
					for (int i = 0; i < NUM_PTR; i++) begin
						ptr_r[u][b][i]  <= PTR_RST;
						mod_r[u][b][i]  <= PTR_RST;
						len_r[u][b][i]  <= PTR_RST;
						base_r[u][b][i] <= PTR_RST;
					end
				end
			end
		end else if (ce_i) begin
			bank_r <= bank_sel_i;
			for (int u = 0; u < NUM_UNIT; u++) begin
				vld_r[u]  <= acc_en[u];
				addr_r[u] <= {page_r[u], calc_adr[u]};
				if (do_upd[u]) begin
					ptr_r[u][bank_r][acc_pidx[u]] <= calc_nxt[u];
				end
			end
			if (wr_en_i) begin
				case (wr_kind_i)
					WR_PTR:  ptr_r[wr_unit_i][bank_r][wr_idx_i]  <= wr_data_i;
					WR_MOD:  mod_r[wr_unit_i][bank_r][wr_idx_i]  <= wr_data_i;
					WR_LEN:  len_r[wr_unit_i][bank_r][wr_idx_i]  <= wr_data_i;
					WR_BASE: base_r[wr_unit_i][bank_r][wr_idx_i] <= wr_data_i;
					WR_PAGE: page_r[wr_unit_i] <= wr_data_i[GW-1:0];
					default: ;
				endcase
			end
		end
	end

	assign bank_o    = bank_r;
	assign dm_addr_o = addr_r[UNIT_DM];
	assign dm_vld_o  = vld_r[UNIT_DM];
	assign pm_addr_o = addr_r[UNIT_PM];
	assign pm_vld_o  = vld_r[UNIT_PM];

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	AST_PTR_WRITE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		ce_i && wr_en_i && wr_kind_i == WR_PTR && !dm_en_i && !pm_en_i
		|=> ptr_r[$past(wr_unit_i)][$past(bank_r)][$past(wr_idx_i)] == $past(wr_data_i))
		else $error("pointer write not stored");

	AST_POST_REG: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		ce_i && dm_en_i && dm_mode_i == MODE_POST_REG && sel_len[0] == 16'h0000
		&& !wr_en_i && bank_sel_i == bank_r
		|=> dm_vld_o && dm_addr_o[PW-1:0] == $past(sel_ptr[0])
		&& ptr_r[0][bank_r][$past(dm_pidx_i)] == $past(sel_ptr[0]) + $past(sel_mod[0]))
		else $error("post modify by register wrong");

	AST_PRE_KEEP: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		ce_i && pm_en_i && pm_mode_i == MODE_PRE_KEEP_REG && !wr_en_i
		&& bank_sel_i == bank_r
		|=> ptr_r[1][bank_r][$past(pm_pidx_i)] == $past(sel_ptr[1])
		&& pm_addr_o[PW-1:0] == $past(calc_nxt[1]))
		else $error("premodify without update changed pointer");

	AST_IMM_SIGN: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		ce_i && dm_en_i && dm_mode_i == MODE_PRE_IMM && sel_len[0] == 16'h0000
		|=> dm_addr_o[PW-1:0]
		== $past(sel_ptr[0]) + {{8{$past(dm_imm_i[IW-1])}}, $past(dm_imm_i)})
		else $error("immediate offset not sign extended");

	AST_CIRC_RANGE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		ce_i && dm_en_i && dm_mode_i == MODE_POST_REG && sel_len[0] != 16'h0000
		&& (sel_ptr[0] - sel_base[0]) < sel_len[0]
		&& ($signed(sel_mod[0]) < $signed({1'b0, sel_len[0]}))
		&& (-$signed(sel_mod[0]) < $signed({1'b0, sel_len[0]}))
		&& !wr_en_i && bank_sel_i == bank_r
		|=> (ptr_r[0][bank_r][$past(dm_pidx_i)] - $past(sel_base[0])) < $past(sel_len[0]))
		else $error("circular pointer left its buffer");

	AST_PAGE_HOLD: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		ce_i && pm_en_i && sel_len[1] != 16'h0000 && !wr_en_i
		|=> pm_addr_o[GW+PW-1:PW] == page_r[1])
		else $error("circular access crossed a page");

	AST_BANK_SWAP: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		ce_i && bank_sel_i != bank_r ##1 ce_i && dm_en_i
		|-> sel_ptr[0] == ptr_r[0][bank_o][dm_pidx_i] && bank_o == $past(bank_sel_i))
		else $error("register set switch slower than one cycle");

	AST_DUAL_ISSUE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		ce_i && dm_en_i && pm_en_i |=> dm_vld_o && pm_vld_o)
		else $error("generators did not issue together");

	AST_PAGE_BITS: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		ce_i && dm_en_i |=> dm_addr_o[GW+PW-1:PW] == $past(page_r[0]))
		else $error("upper address bits not from page");

endmodule : dual_data_address_generator

`default_nettype wire

// ### verification/mem_bus_model.sv
// Memory bus side model: counts address beats taken from both buses
`timescale 1ns/1ps
`default_nettype none

module mem_bus_model (
	// Clock and reset
	input  wire logic mclk_i,
	input  wire logic resetn_i,
	// Address strobes
	input  wire logic dm_vld_i,
	input  wire logic pm_vld_i,
	// Beat count
	output var  int   beats_o
);
	// Both buses may strobe in one cycle, so both are summed
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i)
			beats_o <= 0;
		else
			beats_o <= beats_o + int'(dm_vld_i) + int'(pm_vld_i);
	end
endmodule : mem_bus_model

`default_nettype wire

// ### verification/dual_data_address_generator_tb_top.sv
// Random self-checking bench for the dual data address generator
`timescale 1ns/1ps
`default_nettype none

module dual_data_address_generator_tb_top
	import dadg_pkg::*;
;
	logic mclk_i = 0, resetn_i = 0, ce = 0, wen = 0, wunit = 0, bsel = 0;
	logic den = 0, pen = 0, dv, pv, bnk, mb = 0, xv = 0, xw = 0;
	wr_kind_t wkind = WR_PTR;
	acc_mode_t dmode = MODE_POST_REG, pmode = MODE_POST_REG;
	logic [1:0] widx = 0, dp = 0, dm = 0, pp = 0, pmi = 0;
	logic [7:0] dimm = 0, pimm = 0, rg [2];
	logic [15:0] wdata = 0, lf = 16'h9b3f;
	logic [15:0] rp [2][2][4], rm [2][2][4], rl [2][2][4], rb [2][2][4];
	logic [23:0] da, pa;
	int num_errors = 0, checked = 0, beats, exp_beats = 0;

	dual_data_address_generator u_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce),
		.wr_en_i(wen), .wr_unit_i(wunit), .wr_kind_i(wkind), .wr_idx_i(widx),
		.wr_data_i(wdata), .bank_sel_i(bsel), .bank_o(bnk), .dm_en_i(den),
		.dm_mode_i(dmode), .dm_pidx_i(dp), .dm_midx_i(dm), .dm_imm_i(dimm),
		.pm_en_i(pen), .pm_mode_i(pmode), .pm_pidx_i(pp), .pm_midx_i(pmi),
		.pm_imm_i(pimm), .dm_addr_o(da), .dm_vld_o(dv), .pm_addr_o(pa), .pm_vld_o(pv));
	mem_bus_model u_mem (.mclk_i(mclk_i), .resetn_i(resetn_i), .dm_vld_i(dv),
		.pm_vld_i(pv), .beats_o(beats));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] rnd();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf;
	endfunction : rnd

	// Offsets kept below the ring length of 10
	function automatic logic [15:0] sm();
		int v;
		v = int'(rnd() % 16'd19) - 9;
		return 16'(v);
	endfunction : sm

	function automatic logic [15:0] wrap(input logic [15:0] p, o, l, b);
		int n;
		if (l == 16'h0000)
			return p + o;
		n = int'(p - b) + int'($signed(o));
		if (n < 0)
			n = n + int'(l);
		else if (n >= int'(l))
			n = n - int'(l);
		return b + 16'(n);
	endfunction : wrap

	task automatic side(input int u, input acc_mode_t md, input logic [1:0] pi, mi,
		input logic [7:0] im, output logic [23:0] ea, output logic [15:0] np);
		logic [15:0] o, p, q;
		o = (md == MODE_POST_IMM || md == MODE_PRE_IMM) ? {{8{im[7]}}, im} : rm[mb][u][mi];
		p = rp[mb][u][pi];
		q = wrap(p, o, rl[mb][u][pi], rb[mb][u][pi]);
		ea = {rg[u], (md == MODE_POST_REG || md == MODE_POST_IMM) ? p : q};
		np = (md == MODE_PRE_KEEP_REG) ? p : q;
	endtask : side

	task automatic chk_bit(input string n, input logic e, g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s exp %b got %b", n, e, g);
		end
	endtask : chk_bit

	task automatic chk_addr(input string n, input logic [23:0] e, g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask : chk_addr

	// One clock: predict, pass the edge, update the model, then compare
	task automatic cyc();
		logic [23:0] ea, eb;
		logic [15:0] na, nb;
		logic ev, fv;
		side(0, dmode, dp, dm, dimm, ea, na);
		side(1, pmode, pp, pmi, pimm, eb, nb);
		ev = ce & den;
		fv = ce & pen;
		// Strobes freeze during a stall, so the bus model counts them again
		exp_beats += int'(xv) + int'(xw);
		@(posedge mclk_i);
		#1;
		if (ce) begin
			xv = den;
			xw = pen;
			if (ev) rp[mb][0][dp] = na;
			if (fv) rp[mb][1][pp] = nb;
			if (wen && wkind == WR_PAGE) rg[wunit] = wdata[7:0];
			else if (wen) begin
				case (wkind)
					WR_PTR: rp[mb][wunit][widx] = wdata;
					WR_MOD: rm[mb][wunit][widx] = wdata;
					WR_LEN: rl[mb][wunit][widx] = wdata;
					default: rb[mb][wunit][widx] = wdata;
				endcase
			end
			mb = bsel;
		end
		chk_bit("dm_vld", xv, dv);
		chk_bit("pm_vld", xw, pv);
		chk_bit("bank", mb, bnk);
		if (ev) chk_addr("dm_addr", ea, da);
		if (fv) chk_addr("pm_addr", eb, pa);
	endtask : cyc

	task automatic put(input logic u, input wr_kind_t k, input logic [1:0] i,
		input logic [15:0] d);
		wen = 1;
		wunit = u;
		wkind = k;
		widx = i;
		wdata = d;
		cyc();
	endtask : put

	task automatic results();
		if (num_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #2 mclk_i = ~mclk_i;
	end

	initial begin
		#20000;
		num_errors++;
		results();
	end

	initial begin
		logic [15:0] b;
		rp = '{default: 16'h0000};
		rm = rp;
		rl = rp;
		rb = rp;
		rg = '{default: 8'h00};
		repeat (12) @(posedge mclk_i);
		chk_addr("rst_dm", 24'h000000, da);
		chk_addr("rst_pm", 24'h000000, pa);
		#1 resetn_i = 1;
		ce = 1;
		// Ring on index 1 in both sets, linear elsewhere
		for (int s = 0; s < 2; s++) begin
			bsel = s[0];
			wen = 0;
			cyc();
			for (int u = 0; u < 2; u++) begin
				for (int i = 0; i < 4; i++) begin
					b = 16'h0100 + 16'(s * 64 + u);
					put(u[0], WR_MOD, i[1:0], sm());
					put(u[0], WR_BASE, i[1:0], (i == 1) ? b : 16'h0000);
					put(u[0], WR_LEN, i[1:0], (i == 1) ? 16'h000a : 16'h0000);
					put(u[0], WR_PTR, i[1:0], (i == 1) ? b + 16'h0003 : rnd());
				end
				put(u[0], WR_PAGE, 2'h0, rnd());
			end
		end
		// Random traffic with writes, bank flips and stalls mixed in
		repeat (400) begin
			ce = (rnd() % 16'd8) != 16'h0000;
			den = rnd() > 16'h3000;
			pen = rnd() > 16'h3000;
			dmode = acc_mode_t'(rnd() % 16'd5);
			pmode = acc_mode_t'(rnd() % 16'd5);
			dp = 2'(rnd() >> 14);
			pp = 2'(rnd() >> 14);
			dm = 2'(rnd() >> 14);
			pmi = 2'(rnd() >> 14);
			dimm = 8'((dp == 2'h1) ? sm() : rnd());
			pimm = 8'((pp == 2'h1) ? sm() : rnd());
			if (rnd() < 16'h1000) bsel = ~bsel;
			wen = rnd() < 16'h3000;
			wunit = 1'(rnd() >> 15);
			wkind = (rnd() < 16'h8000) ? WR_PTR : WR_PAGE;
			widx = 2'h0;
			wdata = rnd();
			cyc();
		end
		chk_addr("beats", 24'(exp_beats), 24'(beats));
		results();
	end
endmodule : dual_data_address_generator_tb_top

`default_nettype wire
